// ===== pkg/fsp_pkg.sv
package fsp_pkg;

	localparam int unsigned CLK_MHZ = 20;
	localparam int unsigned OP_TIME_US = 2000;
	localparam int unsigned OP_CYCLES = OP_TIME_US * CLK_MHZ;

	localparam logic [7:0] OFS_ADDR_LOW = 8'h00;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h04;
	localparam logic [7:0] OFS_DATA_LOW = 8'h08;
	localparam logic [7:0] OFS_DATA_HIGH = 8'h0c;
	localparam logic [7:0] OFS_CTRL = 8'h10;
	localparam logic [7:0] OFS_KEY = 8'h14;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h18;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h1c;
	localparam logic [7:0] OFS_CONFIG = 8'h20;

	localparam int unsigned ADDR_W = 15;
	localparam int unsigned DATA_W = 14;
	localparam int unsigned ROW_WORDS = 32;
	localparam int unsigned LATCH_SEL_W = 5;

	localparam int unsigned CTL_RD = 0;
	localparam int unsigned CTL_WR = 1;
	localparam int unsigned CTL_ALLOW = 2;
	localparam int unsigned CTL_ABORT = 3;
	localparam int unsigned CTL_FREE = 4;
	localparam int unsigned CTL_LATCH_ONLY = 5;
	localparam int unsigned CTL_CFG_SEL = 6;

	localparam int unsigned IRQ_DONE = 0;
	localparam int unsigned IRQ_REFUSED = 1;
	localparam int unsigned IRQ_ABORT = 2;
	localparam int unsigned IRQ_W = 3;

	localparam logic [7:0] KEY_FIRST = 8'h55;
	localparam logic [7:0] KEY_SECOND = 8'haa;

	localparam logic [13:0] LATCH_ERASED = 14'h3fff;
	localparam logic [1:0] GUARD_OFF = 2'b11;
	localparam logic [1:0] GUARD_LOW = 2'b10;
	localparam logic [1:0] GUARD_HALF = 2'b01;
	localparam logic [14:0] GUARD_LOW_END = 15'h0200;
	localparam logic [14:0] GUARD_HALF_END = 15'h4000;

	typedef enum logic [2:0] {
		FSP_IDLE = 3'b000,
		FSP_RD_WAIT = 3'b001,
		FSP_RD_FETCH = 3'b010,
		FSP_NOP1 = 3'b011,
		FSP_NOP2 = 3'b100,
		FSP_PROG = 3'b101,
		FSP_WAIT = 3'b110
	} fsp_state_e;

	typedef enum logic [1:0] {
		FSP_KEY_NONE = 2'b00,
		FSP_KEY_HALF = 2'b01,
		FSP_KEY_FULL = 2'b10
	} fsp_key_e;

endpackage

// ===== src/fsp_op_timer.sv
`timescale 1ns/100ps
module fsp_op_timer #(
	parameter int unsigned WIDTH = 16
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic start,
	input wire logic abort,
	input wire logic [WIDTH-1:0] load,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] cnt_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= '0;
		end else if (abort) begin
			cnt_ff <= '0;
		end else if (start) begin
			cnt_ff <= load;
		end else if (cnt_ff != '0) begin
			cnt_ff <= cnt_ff - 1'b1;
		end
	end

	assign busy = (cnt_ff != '0);
	assign done = (cnt_ff == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule

// ===== src/fsp_ctrl.sv
`timescale 1ns/100ps
// Operation
// - data pair 14-bit word, address 15-bit
// - address high/low bytes reach 32K words
// - go bits set-only, hardware clears
// - write needs allow bit, cleared at power-up
// - reset during write sets abort flag
// - key register reads as zero
// - writes refused without key pattern
// - code lock blocks external programmer
// - only bulk erase or power-up reset releases code lock
// - guard blocks self-write over regions
// - erase acts on 32-word rows only
// - 32 write latches loaded through data
// - internal timer sets operation duration
// - low five bits pick latch; refill 3fff
// - stall core about 2 ms
// - fetch second cycle, data next cycle
module fsp_ctrl
	import fsp_pkg::*;
#(
	parameter int unsigned OP_TIME_CYCLES = OP_CYCLES
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic soft_rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic irq,
	output logic cpu_force_nop,
	output logic cpu_stall,
	output logic [14:0] fl_addr,
	output logic fl_cfg_space,
	output logic fl_rd,
	input wire logic [13:0] fl_rdata,
	output logic fl_wr,
	output logic [13:0] fl_wdata,
	output logic fl_erase_row,
	output logic fl_bulk_erase,
	input wire logic ext_cfg_wr,
	input wire logic ext_code_lock_n,
	input wire logic [1:0] ext_guard,
	input wire logic ext_bulk_erase,
	output logic ext_access_allow
);
	logic [7:0] addr_low_ff;
	logic [6:0] addr_high_ff;
	logic [7:0] data_low_ff;
	logic [5:0] data_high_ff;
	logic [6:0] ctrl_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic code_lock_n_ff;
	logic [1:0] guard_ff;
	logic [31:0] prdata_ff;
	logic [13:0] latch_mem [ROW_WORDS];
	logic [LATCH_SEL_W-1:0] prog_idx_ff;
	fsp_state_e state_ff;
	fsp_key_e key_ff;
	logic [14:0] flash_addr;
	logic setup;
	logic acc;
	logic wr_acc;
	logic rd_acc;
	logic mapped;
	logic ctrl_wr;
	logic rd_go;
	logic wr_go;
	logic wr_ok;
	logic guarded;
	logic busy;
	logic tmr_start;
	logic tmr_busy;
	logic tmr_done;
	logic op_end;
	logic ev_refused;
	logic ev_abort;
	logic [31:0] nxt_prdata;

	assign flash_addr = {addr_high_ff, addr_low_ff};
	assign setup = psel && !penable;
	assign acc = psel && penable;
	assign wr_acc = acc && pwrite;
	assign rd_acc = acc && !pwrite;
	assign ctrl_wr = wr_acc && (paddr == OFS_CTRL);
	assign pready = 1'b1;
	assign pslverr = acc && !mapped;
	assign prdata = prdata_ff;
	assign busy = (state_ff != FSP_IDLE);
	assign ext_access_allow = code_lock_n_ff;

	always_comb begin
		mapped = 1'b1;
		nxt_prdata = 32'h0000_0000;
		unique case (paddr)
			OFS_ADDR_LOW: nxt_prdata[7:0] = addr_low_ff;
			OFS_ADDR_HIGH: nxt_prdata[6:0] = addr_high_ff;
			OFS_DATA_LOW: nxt_prdata[7:0] = data_low_ff;
			OFS_DATA_HIGH: nxt_prdata[5:0] = data_high_ff;
			OFS_CTRL: nxt_prdata[6:0] = ctrl_ff;
			OFS_KEY: nxt_prdata = 32'h0000_0000;
			OFS_IRQ_STAT: nxt_prdata[IRQ_W-1:0] = irq_stat_ff;
			OFS_IRQ_MASK: nxt_prdata[IRQ_W-1:0] = irq_mask_ff;
			OFS_CONFIG: nxt_prdata[2:0] = {guard_ff, code_lock_n_ff};
			default: mapped = 1'b0;
		endcase
	end

	// read data is fetched in the setup cycle so it can come from a flop
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			prdata_ff <= 32'h0000_0000;
		end else if (setup && !pwrite) begin
			prdata_ff <= nxt_prdata;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			addr_low_ff <= 8'h00;
			addr_high_ff <= 7'h00;
		end else if (wr_acc && paddr == OFS_ADDR_LOW) begin
			addr_low_ff <= pwdata[7:0];
		end else if (wr_acc && paddr == OFS_ADDR_HIGH) begin
			addr_high_ff <= pwdata[6:0];
		end
	end

	// a completed fetch wins over a same-cycle firmware write to the pair
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			data_low_ff <= 8'h00;
			data_high_ff <= 6'h00;
		end else if (state_ff == FSP_RD_FETCH) begin
			{data_high_ff, data_low_ff} <= fl_rdata;
		end else if (wr_acc && paddr == OFS_DATA_LOW) begin
			data_low_ff <= pwdata[7:0];
		end else if (wr_acc && paddr == OFS_DATA_HIGH) begin
			data_high_ff <= pwdata[5:0];
		end
	end

	// unlock: the go write must directly follow the two key writes
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			key_ff <= FSP_KEY_NONE;
		end else if (soft_rst || rd_acc) begin
			key_ff <= FSP_KEY_NONE;
		end else if (wr_acc) begin
			if (paddr == OFS_KEY && pwdata[7:0] == KEY_FIRST) begin
				key_ff <= FSP_KEY_HALF;
			end else if (paddr == OFS_KEY && pwdata[7:0] == KEY_SECOND
					&& key_ff == FSP_KEY_HALF) begin
				key_ff <= FSP_KEY_FULL;
			end else begin
				key_ff <= FSP_KEY_NONE;
			end
		end
	end

	assign rd_go = ctrl_wr && pwdata[CTL_RD] && !busy;
	assign wr_go = ctrl_wr && pwdata[CTL_WR] && !busy && !rd_go;

	always_comb begin
		guarded = 1'b0;
		if (!pwdata[CTL_CFG_SEL]) begin
			unique case (guard_ff)
				GUARD_OFF: guarded = 1'b0;
				GUARD_LOW: guarded = (flash_addr < GUARD_LOW_END);
				GUARD_HALF: guarded = (flash_addr < GUARD_HALF_END);
				default: guarded = 1'b1;
			endcase
		end
	end

	assign wr_ok = pwdata[CTL_ALLOW] && ctrl_ff[CTL_ALLOW] && key_ff == FSP_KEY_FULL
		&& !guarded;
	assign ev_refused = wr_go && !wr_ok;
	assign ev_abort = soft_rst && (busy && ctrl_ff[CTL_WR]);
	assign op_end = tmr_done || (state_ff == FSP_NOP2 && ctrl_ff[CTL_LATCH_ONLY]);

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_ff <= 7'h00;
		end else if (soft_rst) begin
			ctrl_ff <= 7'h00;
			ctrl_ff[CTL_ABORT] <= ctrl_ff[CTL_ABORT] || ev_abort;
		end else begin
			if (ctrl_wr) begin
				ctrl_ff[CTL_ALLOW] <= pwdata[CTL_ALLOW];
				ctrl_ff[CTL_ABORT] <= pwdata[CTL_ABORT];
				if (!busy) begin
					ctrl_ff[CTL_FREE] <= pwdata[CTL_FREE];
					ctrl_ff[CTL_LATCH_ONLY] <= pwdata[CTL_LATCH_ONLY];
					ctrl_ff[CTL_CFG_SEL] <= pwdata[CTL_CFG_SEL];
				end
			end
			if (rd_go) begin
				ctrl_ff[CTL_RD] <= 1'b1;
			end else if (state_ff == FSP_RD_FETCH) begin
				ctrl_ff[CTL_RD] <= 1'b0;
			end
			if (wr_go && wr_ok) begin
				ctrl_ff[CTL_WR] <= 1'b1;
			end else if (op_end) begin
				ctrl_ff[CTL_WR] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_ff <= FSP_IDLE;
			prog_idx_ff <= '0;
		end else if (soft_rst) begin
			state_ff <= FSP_IDLE;
			prog_idx_ff <= '0;
		end else begin
			unique case (state_ff)
				FSP_IDLE: begin
					prog_idx_ff <= '0;
					if (rd_go) begin
						state_ff <= FSP_RD_WAIT;
					end else if (wr_go && wr_ok) begin
						state_ff <= FSP_NOP1;
					end
				end
				FSP_RD_WAIT: state_ff <= FSP_RD_FETCH;
				FSP_RD_FETCH: state_ff <= FSP_IDLE;
				FSP_NOP1: state_ff <= FSP_NOP2;
				FSP_NOP2: begin
					if (ctrl_ff[CTL_LATCH_ONLY]) begin
						state_ff <= FSP_IDLE;
					end else if (ctrl_ff[CTL_FREE]) begin
						state_ff <= FSP_WAIT;
					end else begin
						state_ff <= FSP_PROG;
					end
				end
				FSP_PROG: begin
					prog_idx_ff <= prog_idx_ff + 1'b1;
					if (prog_idx_ff == LATCH_SEL_W'(ROW_WORDS - 1)) begin
						state_ff <= FSP_WAIT;
					end
				end
				FSP_WAIT: begin
					if (tmr_done) begin
						state_ff <= FSP_IDLE;
					end
				end
				default: state_ff <= FSP_IDLE;
			endcase
		end
	end

	assign tmr_start = (state_ff == FSP_NOP2) && !ctrl_ff[CTL_LATCH_ONLY];

	fsp_op_timer #(
		.WIDTH(32)
	) u_timer (
		.clk(clk),
		.nrst(nrst),
		.start(tmr_start),
		.abort(soft_rst),
		.load(OP_TIME_CYCLES + ROW_WORDS),
		.busy(tmr_busy),
		.done(tmr_done)
	);

	// latches hold no reset; they are refilled after each program and on reset
	always_ff @(posedge clk) begin
		for (int i = 0; i < ROW_WORDS; i++) begin
			if (!nrst || soft_rst || (tmr_done && !ctrl_ff[CTL_FREE])) begin
				latch_mem[i] <= LATCH_ERASED;
			end else if (state_ff == FSP_NOP2 && !ctrl_ff[CTL_FREE]
					&& addr_low_ff[LATCH_SEL_W-1:0] == LATCH_SEL_W'(i)) begin
				latch_mem[i] <= {data_high_ff, data_low_ff};
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			fl_addr <= 15'h0000;
			fl_cfg_space <= 1'b0;
			fl_rd <= 1'b0;
			fl_wr <= 1'b0;
			fl_wdata <= 14'h0000;
			fl_erase_row <= 1'b0;
			fl_bulk_erase <= 1'b0;
		end else begin
			fl_cfg_space <= ctrl_ff[CTL_CFG_SEL];
			fl_rd <= (state_ff == FSP_RD_WAIT);
			fl_wr <= (state_ff == FSP_PROG);
			fl_erase_row <= (state_ff == FSP_NOP2) && ctrl_ff[CTL_FREE]
				&& !ctrl_ff[CTL_LATCH_ONLY];
			fl_bulk_erase <= ext_bulk_erase;
			if (state_ff == FSP_PROG) begin
				fl_addr <= {flash_addr[14:LATCH_SEL_W], prog_idx_ff};
				fl_wdata <= latch_mem[prog_idx_ff];
			end else if (state_ff == FSP_NOP2 && ctrl_ff[CTL_FREE]) begin
				fl_addr <= {flash_addr[14:LATCH_SEL_W], LATCH_SEL_W'(0)};
			end else begin
				fl_addr <= flash_addr;
			end
		end
	end

	// core sees forced nops on reads and latch loads, a full stall on row operations
	assign cpu_force_nop = (state_ff inside {FSP_RD_WAIT, FSP_RD_FETCH, FSP_NOP1,
		FSP_NOP2});
	assign cpu_stall = (state_ff inside {FSP_PROG, FSP_WAIT}) || tmr_busy;

	// lock only tightens from a config write; bulk erase and power-up reset are the only ways back
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			code_lock_n_ff <= 1'b1;
			guard_ff <= GUARD_OFF;
		end else if (ext_bulk_erase) begin
			code_lock_n_ff <= 1'b1;
			guard_ff <= GUARD_OFF;
		end else if (ext_cfg_wr && code_lock_n_ff) begin
			code_lock_n_ff <= ext_code_lock_n;
			guard_ff <= ext_guard;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			irq_stat_ff <= '0;
			irq_mask_ff <= '0;
		end else begin
			if (wr_acc && paddr == OFS_IRQ_MASK) begin
				irq_mask_ff <= pwdata[IRQ_W-1:0];
			end
			for (int b = 0; b < IRQ_W; b++) begin
				if ((b == IRQ_DONE && op_end) || (b == IRQ_REFUSED && ev_refused)
						|| (b == IRQ_ABORT && ev_abort)) begin
					irq_stat_ff[b] <= 1'b1;
				end else if (wr_acc && paddr == OFS_IRQ_STAT && pwdata[b]) begin
					irq_stat_ff[b] <= 1'b0;
				end
			end
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	a_key_read_zero: assert property (@(posedge clk) disable iff (!nrst)
		setup && !pwrite && paddr == OFS_KEY |=> prdata == 32'h0000_0000)
		else $error("key register read not zero");
	a_go_needs_unlock: assert property (@(posedge clk) disable iff (!nrst)
		$rose(ctrl_ff[CTL_WR]) |-> $past(key_ff) == FSP_KEY_FULL)
		else $error("write started without unlock");
	a_go_needs_allow: assert property (@(posedge clk) disable iff (!nrst)
		$rose(ctrl_ff[CTL_WR]) |-> ctrl_ff[CTL_ALLOW])
		else $error("write started without allow bit");
	a_rd_fetch_time: assert property (@(posedge clk) disable iff (!nrst || soft_rst)
		rd_go |=> state_ff == FSP_RD_WAIT ##1 fl_rd && state_ff == FSP_RD_FETCH
		##1 !ctrl_ff[CTL_RD])
		else $error("read fetch timing wrong");
	a_two_nops: assert property (@(posedge clk) disable iff (!nrst || soft_rst)
		wr_go && wr_ok |=> cpu_force_nop [*2] ##1 !cpu_force_nop)
		else $error("forced nops not two cycles");
	a_wr_set_only: assert property (@(posedge clk) disable iff (!nrst)
		$fell(ctrl_ff[CTL_WR]) |-> $past(op_end) || $past(soft_rst))
		else $error("write go cleared early");
	a_abort_flag: assert property (@(posedge clk) disable iff (!nrst)
		soft_rst && busy && ctrl_ff[CTL_WR] |=> ctrl_ff[CTL_ABORT])
		else $error("abort flag not set");
	a_lock_release: assert property (@(posedge clk) disable iff (!nrst)
		$rose(code_lock_n_ff) |-> $past(ext_bulk_erase))
		else $error("code lock released without bulk erase");
	a_erase_stall: assert property (@(posedge clk) disable iff (!nrst || soft_rst)
		fl_erase_row |-> cpu_stall)
		else $error("core not stalled during erase");
	a_guard_block: assert property (@(posedge clk) disable iff (!nrst)
		wr_go && guarded |=> !ctrl_ff[CTL_WR] && irq_stat_ff[IRQ_REFUSED])
		else $error("guarded write not refused");
endmodule

// ===== dv/fsp_flash_model.sv
`timescale 1ns/100ps
module fsp_flash_model (
	input wire logic clk,
	input wire logic [14:0] fl_addr,
	input wire logic fl_rd,
	output logic [13:0] fl_rdata,
	input wire logic fl_wr,
	input wire logic [13:0] fl_wdata,
	input wire logic fl_erase_row,
	input wire logic fl_bulk_erase
);
	logic [13:0] mem [0:32767];
	logic [13:0] last_ff = 14'h0000;
	// outside a strobe the bus shows junk, so a late sample never matches by luck
	assign fl_rdata = fl_rd ? mem[fl_addr] : ~last_ff;
	initial begin
		for (int i = 0; i < 32768; i++) begin
			mem[i] = 14'h3fff;
		end
	end
	always @(posedge clk) begin
		if (fl_rd) begin
			last_ff <= mem[fl_addr];
		end
		if (fl_wr) begin
			mem[fl_addr] <= fl_wdata;
		end
		if (fl_erase_row) begin
			for (int i = 0; i < 32; i++) begin
				mem[{fl_addr[14:5], 5'(i)}] <= 14'h3fff;
			end
		end
		if (fl_bulk_erase) begin
			for (int i = 0; i < 32768; i++) begin
				mem[i] <= 14'h3fff;
			end
		end
	end
endmodule

// ===== dv/test_fsp_ctrl.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; $display("MISMATCH %0t value differs", $time); end end
module test_fsp_ctrl;
	import fsp_pkg::*;
	// short operation time keeps the run brief
	localparam int unsigned OP_T = 64;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic soft_rst = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd_v;
	logic pready, pslverr, irq, cpu_force_nop, cpu_stall, fl_cfg_space, fl_rd, fl_wr;
	logic fl_erase_row, fl_bulk_erase, ext_access_allow, err_v;
	logic ext_cfg_wr = 1'b0;
	logic ext_code_lock_n = 1'b1;
	logic ext_bulk_erase = 1'b0;
	logic [1:0] ext_guard = 2'b11;
	logic [14:0] fl_addr;
	logic [13:0] fl_rdata, fl_wdata;
	int bad_count = 0;
	int checks_done = 0;
	int cycles = 0;
	int wr_pulses = 0;
	int stall_n = 0;

	fsp_ctrl #(.OP_TIME_CYCLES(OP_T)) dut_u (.clk(clk), .nrst(nrst), .soft_rst(soft_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
		.cpu_force_nop(cpu_force_nop), .cpu_stall(cpu_stall), .fl_addr(fl_addr),
		.fl_cfg_space(fl_cfg_space), .fl_rd(fl_rd), .fl_rdata(fl_rdata), .fl_wr(fl_wr),
		.fl_wdata(fl_wdata), .fl_erase_row(fl_erase_row), .fl_bulk_erase(fl_bulk_erase),
		.ext_cfg_wr(ext_cfg_wr), .ext_code_lock_n(ext_code_lock_n), .ext_guard(ext_guard),
		.ext_bulk_erase(ext_bulk_erase), .ext_access_allow(ext_access_allow));
	fsp_flash_model flash_u (.clk(clk), .fl_addr(fl_addr), .fl_rd(fl_rd), .fl_rdata(fl_rdata),
		.fl_wr(fl_wr), .fl_wdata(fl_wdata), .fl_erase_row(fl_erase_row),
		.fl_bulk_erase(fl_bulk_erase));

	initial begin
		forever #25 clk = ~clk;
	end
	always @(posedge clk) begin
		cycles++;
		wr_pulses += fl_wr;
		stall_n += cpu_stall;
		if (cycles == 20000) begin
			bad_count++;
			report_and_stop();
		end
	end

	task report_and_stop();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		rd_v = prdata;
		err_v = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask
	task rd(input logic [7:0] a);
		apb(1'b0, a, 32'h0);
	endtask
	task set_addr(input logic [14:0] a);
		wr(OFS_ADDR_LOW, {24'h0, a[7:0]});
		wr(OFS_ADDR_HIGH, {25'h0, a[14:8]});
	endtask
	task go(input logic [7:0] c);
		wr(OFS_CTRL, {24'h0, c & 8'hfd});
		wr(OFS_KEY, {24'h0, KEY_FIRST});
		wr(OFS_KEY, {24'h0, KEY_SECOND});
		wr(OFS_CTRL, {24'h0, c});
	endtask
	task wait_idle();
		int n;
		n = 0;
		repeat (3) @(posedge clk);
		while (cpu_stall !== 1'b0 && n < 1000) begin
			@(posedge clk);
			n++;
		end
	endtask
	task stat_is(input int b);
		rd(OFS_IRQ_STAT);
		`CHK(rd_v[b], 1'b1)
		wr(OFS_IRQ_STAT, 32'h7);
	endtask

	task t_reset();
		rd(OFS_CTRL);
		`CHK(rd_v, 32'h0)
		wr(OFS_KEY, 32'h55);
		rd(OFS_KEY);
		`CHK(rd_v, 32'h0)
		rd(8'h40);
		`CHK(err_v, 1'b1)
		wr(OFS_CTRL, 32'h40);
		@(posedge clk);
		#1;
		`CHK(fl_cfg_space, 1'b1)
		wr(OFS_CTRL, 32'h0);
	endtask
	task t_read();
		flash_u.mem[15'h5a37] = 14'h2bcd;
		set_addr(15'h5a37);
		wr(OFS_CTRL, 32'h1);
		#1;
		`CHK(cpu_force_nop, 1'b1)
		repeat (3) @(posedge clk);
		rd(OFS_DATA_LOW);
		`CHK(rd_v, 32'hcd)
		rd(OFS_DATA_HIGH);
		`CHK(rd_v, 32'h2b)
		rd(OFS_CTRL);
		`CHK(rd_v[0], 1'b0)
	endtask
	task t_refuse();
		wr(OFS_IRQ_MASK, 32'h2);
		wr(OFS_CTRL, 32'h4);
		wr(OFS_CTRL, 32'h6);
		rd(OFS_CTRL);
		`CHK(rd_v[1], 1'b0)
		`CHK(irq, 1'b1)
		wr(OFS_IRQ_STAT, 32'h2);
		// the clear lands at the edge the task returns on; let it settle
		#1;
		`CHK(irq, 1'b0)
		wr(OFS_KEY, 32'h55);
		rd(OFS_KEY);
		wr(OFS_KEY, 32'haa);
		wr(OFS_CTRL, 32'h6);
		stat_is(1);
	endtask
	task t_program();
		flash_u.mem[15'h1a44] = 14'h0000;
		set_addr(15'h1a43);
		wr(OFS_DATA_LOW, 32'h34);
		wr(OFS_DATA_HIGH, 32'h12);
		go(8'h26);
		repeat (4) @(posedge clk);
		wr_pulses = 0;
		stall_n = 0;
		go(8'h06);
		wait_idle();
		`CHK(wr_pulses, 32)
		`CHK(stall_n >= OP_T, 1'b1)
		`CHK(flash_u.mem[15'h1a43], 14'h1234)
		`CHK(flash_u.mem[15'h1a44], 14'h3fff)
		stat_is(0);
		flash_u.mem[15'h1a43] = 14'h0000;
		// a program go also loads the addressed latch, so aim at another word
		set_addr(15'h1a45);
		go(8'h06);
		wait_idle();
		`CHK(flash_u.mem[15'h1a43], 14'h3fff)
		`CHK(flash_u.mem[15'h1a45], 14'h1234)
	endtask
	task t_erase();
		flash_u.mem[15'h2a05] = 14'h0000;
		flash_u.mem[15'h2a20] = 14'h0000;
		set_addr(15'h2a1f);
		go(8'h16);
		wait_idle();
		`CHK(flash_u.mem[15'h2a05], 14'h3fff)
		`CHK(flash_u.mem[15'h2a20], 14'h0000)
	endtask
	task t_abort();
		wr(OFS_IRQ_MASK, 32'h4);
		go(8'h06);
		repeat (10) @(posedge clk);
		soft_rst <= 1'b1;
		@(posedge clk);
		soft_rst <= 1'b0;
		rd(OFS_CTRL);
		`CHK(rd_v, 32'h8)
		`CHK(irq, 1'b1)
		wr(OFS_CTRL, 32'h0);
		wr(OFS_IRQ_STAT, 32'h7);
	endtask
	task t_protect();
		ext_code_lock_n <= 1'b0;
		ext_guard <= 2'b00;
		ext_cfg_wr <= 1'b1;
		@(posedge clk);
		ext_cfg_wr <= 1'b0;
		rd(OFS_CONFIG);
		`CHK(rd_v, 32'h0)
		`CHK(ext_access_allow, 1'b0)
		go(8'h06);
		stat_is(1);
		ext_bulk_erase <= 1'b1;
		@(posedge clk);
		ext_bulk_erase <= 1'b0;
		rd(OFS_CONFIG);
		`CHK(rd_v, 32'h7)
		`CHK(ext_access_allow, 1'b1)
	endtask

	initial begin
		repeat (8) @(posedge clk);
		nrst <= 1'b1;
		t_reset();
		t_read();
		t_refuse();
		t_program();
		t_erase();
		t_abort();
		t_protect();
		report_and_stop();
	end
endmodule
